// File: src/dac_front_end.sv
// Sample FIFO and the converter front end: select, retrace, latches
`timescale 1ns/10ps

// ********************************************************************
// Sample FIFO
// ********************************************************************
module sample_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data,
   output logic [$clog2(DEPTH+1)-1:0] o_level
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH+1);
   localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
   localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   logic push;
   logic pop;

   // Handshakes on both sides
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;
   assign o_out_valid = (count != '0);
   assign o_out_data = mem[rd_ptr];
   assign o_level = count;

   // Occupancy
   always_comb begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + CNT_W'(1);
      end else if (pop && !push) begin
         next_count = count - CNT_W'(1);
      end
   end

   // Count and registered ready; ready drops only when really full
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         count <= '0;
         o_in_ready <= 1'b1;
      end else begin
         count <= next_count;
         o_in_ready <= (next_count != FULL);
      end
   end

   // Write side
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         wr_ptr <= '0;
      end else if (push) begin
         wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + PTR_W'(1);
      end
   end

   // Storage has no reset; only written cells are ever read
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr] <= i_in_data;
      end
   end

   // Read side
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         rd_ptr <= '0;
      end else if (pop) begin
         rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + PTR_W'(1);
      end
   end
endmodule : sample_fifo

// ********************************************************************
// Front end top
// ********************************************************************
module dac_front_end #(
   parameter int CONV_DIV_P = dac_front_pkg::CONV_DIV,
   parameter int FIFO_DEPTH_P = dac_front_pkg::FIFO_DEPTH
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [dac_front_pkg::DATA_W-1:0] i_primary_word,
   input wire logic [dac_front_pkg::DATA_W-1:0] i_secondary_word,
   input wire logic i_word_select,
   input wire logic i_retrace_force,
   input wire logic i_sample_valid,
   input wire logic i_retrace_current_on,
   output logic o_sample_ready,
   input wire logic [dac_front_pkg::ADDR_W-1:0] i_addr,
   input wire logic [dac_front_pkg::BUS_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [dac_front_pkg::BUS_W-1:0] o_rdata,
   output logic [dac_front_pkg::THERM_W-1:0] o_therm,
   output logic [dac_front_pkg::LOW_W-1:0] o_low_bits,
   output logic o_retrace_bit,
   output logic [dac_front_pkg::UNITS_W-1:0] o_true_units
);
   import dac_front_pkg::*;

   localparam int DIV_W = (CONV_DIV_P > 1) ? $clog2(CONV_DIV_P) : 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CONV_DIV_P - 1);
   localparam int LVL_W = $clog2(FIFO_DEPTH_P + 1);

   pins_s pins_raw;
   pins_s pins_meta;
   pins_s pins_s2;
   logic retrace_held;
   logic force_eff;
   sample_s mux_out;
   sample_s fifo_out;
   logic fifo_valid;
   logic fifo_ready;
   logic fifo_in_ready;
   logic [LVL_W-1:0] fifo_level;
   logic [DIV_W-1:0] div_cnt;
   logic conv_tick;
   logic slave_tick;
   sample_s master;
   logic [THERM_W-1:0] next_therm;
   logic [1:0] ctrl;
   logic underrun;
   logic retrace_on;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   assign pins_raw = '{valid: i_sample_valid,
                       strap_on: i_retrace_current_on,
                       retrace_force: i_retrace_force,
                       word_select: i_word_select,
                       secondary: i_secondary_word,
                       primary: i_primary_word};

   // Two flops for every pin; the first stage is read by nothing else
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         pins_meta <= '0;
         pins_s2 <= '0;
      end else begin
         pins_meta <= pins_raw;
         pins_s2 <= pins_meta;
      end
   end

   // ****************************************************************
   // Word select and retrace logic
   // ****************************************************************
   // Capture retrace only while primary selected; frozen otherwise
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         retrace_held <= 1'b0;
      end else if (pins_s2.word_select) begin
         retrace_held <= pins_s2.retrace_force;
      end
   end

   // A stuck high with select low never clears; source must avoid it
   assign force_eff = pins_s2.word_select ? pins_s2.retrace_force
                                          : retrace_held;

   // Mux and force; both paths run at the full sample rate
   always_comb begin
      mux_out.retrace = 1'b0;
      mux_out.data = pins_s2.word_select ? pins_s2.primary
                                         : pins_s2.secondary;
      if (force_eff) begin
         mux_out.retrace = 1'b1;
         mux_out.data = '1;
      end
   end

   // ****************************************************************
   // Sample buffer
   // ****************************************************************
   // Interleaved words queue here in arrival order
   sample_fifo #(
      .WIDTH($bits(sample_s)),
      .DEPTH(FIFO_DEPTH_P)
   ) u_fifo (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_in_valid(pins_s2.valid),
      .o_in_ready(fifo_in_ready),
      .i_in_data(mux_out),
      .o_out_valid(fifo_valid),
      .i_out_ready(fifo_ready),
      .o_out_data(fifo_out),
      .o_level(fifo_level)
   );

   // Ready port registered so the output is a plain flop
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_sample_ready <= 1'b0;
      end else begin
         o_sample_ready <= fifo_in_ready;
      end
   end

   // ****************************************************************
   // Conversion rate divider
   // ****************************************************************
   // One-cycle tick stands in for the converter clock falling edge
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         div_cnt <= '0;
         conv_tick <= 1'b0;
      end else if (!ctrl[CTRL_CONV_EN]) begin
         div_cnt <= '0;
         conv_tick <= 1'b0;
      end else begin
         div_cnt <= (div_cnt == DIV_LAST) ? '0 : div_cnt + DIV_W'(1);
         conv_tick <= (div_cnt == DIV_LAST);
      end
   end

   assign fifo_ready = conv_tick; // Drain stalls between ticks

   // ****************************************************************
   // Master latch and encoder
   // ****************************************************************
   // Master latch holds last word when the buffer runs dry
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         master <= '0;
         slave_tick <= 1'b0;
      end else begin
         slave_tick <= conv_tick;
         if (conv_tick && fifo_valid) begin
            master <= fifo_out;
         end
      end
   end

   // Upper value n lights the n lowest lines
   always_comb begin
      for (int i = 0; i < THERM_W; i++) begin
         next_therm[i] = (32'(master.data[DATA_W-1 -: TOP_W]) > i);
      end
   end

   assign retrace_on = pins_s2.strap_on && ctrl[CTRL_RETRACE_EN];

   // ****************************************************************
   // Slave latch and switch weights
   // ****************************************************************
   // Slave updates one cycle after master so all lines move together
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_therm <= '0;
         o_low_bits <= '0;
         o_retrace_bit <= 1'b0;
      end else if (slave_tick) begin
         o_therm <= next_therm;
         o_low_bits <= master.data[LOW_W-1:0];
         o_retrace_bit <= master.retrace && retrace_on;
      end
   end

   // Units steered to the true output; more units means more negative
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_true_units <= '0;
      end else if (slave_tick) begin
         o_true_units <= UNITS_W'(master.data)
            + ((master.retrace && retrace_on) ? RETRACE_UNITS
                                              : '0);
      end
   end

   // ****************************************************************
   // Register bus
   // ****************************************************************
   // Control register
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         ctrl <= CTRL_RESET;
      end else if (i_wr && i_addr == REG_CTRL) begin
         ctrl <= i_wdata[1:0];
      end
   end

   // Underrun sticky; a new underrun beats a same-cycle clear
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         underrun <= 1'b0;
      end else if (conv_tick && !fifo_valid) begin
         underrun <= 1'b1;
      end else if (i_wr && i_addr == REG_STATUS
                   && i_wdata[STAT_UNDERRUN]) begin
         underrun <= 1'b0;
      end
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= '0;
         if (i_rd) begin
            unique case (i_addr)
               REG_CTRL: o_rdata <= BUS_W'(ctrl);
               REG_STATUS: o_rdata <= BUS_W'({fifo_level, 2'b00,
                  pins_s2.word_select, underrun});
               REG_CODE: o_rdata <= BUS_W'({o_retrace_bit, o_therm,
                  o_low_bits});
               default: o_rdata <= '0;
            endcase
         end
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   AST_THERM_SHAPE: assert property (
      ((o_therm + 7'(1)) & o_therm) == '0)
      else $error("thermometer lines not contiguous from bottom");

   AST_FORCE_ALL_ONES: assert property (
      force_eff |-> (mux_out.retrace && mux_out.data == 8'hFF))
      else $error("retrace force did not set all nine bits");

   AST_PRIMARY_PATH: assert property (
      (pins_s2.word_select && !pins_s2.retrace_force)
      |-> (mux_out.data == pins_s2.primary && !mux_out.retrace))
      else $error("primary word not passed while selected");

   AST_SECONDARY_PATH: assert property (
      (!pins_s2.word_select && !retrace_held)
      |-> (mux_out.data == pins_s2.secondary && !mux_out.retrace))
      else $error("secondary word not passed while selected");

   AST_RETRACE_HOLD: assert property (
      (!pins_s2.word_select && $past(pins_s2.word_select))
      |-> force_eff == $past(pins_s2.retrace_force))
      else $error("retrace not held from select fall");

   AST_MASTER_LOAD: assert property (
      (conv_tick && fifo_valid) |=> master == $past(fifo_out))
      else $error("master latch missed a word");

   AST_SLAVE_FOLLOW: assert property (
      (conv_tick && fifo_valid) |=> ##1
      (o_low_bits == $past(fifo_out.data[LOW_W-1:0], 2)))
      else $error("slave latch not one cycle behind master");

   AST_STRAP_OFF: assert property (
      (slave_tick && !retrace_on) |=> !o_retrace_bit)
      else $error("retrace bit set while retrace current off");

   AST_UNIT_SUM: assert property (
      slave_tick |=> o_true_units == UNITS_W'($past(master.data))
      + (($past(master.retrace) && $past(retrace_on)) ? RETRACE_UNITS
                                                      : '0))
      else $error("steered units do not match latched code");

   AST_TICK_SPACING: assert property (
      conv_tick |=> !conv_tick || CONV_DIV_P == 1)
      else $error("conversion ticks closer than divider allows");
endmodule : dac_front_end

// File: src/dac_front_pkg.sv
// Constants, types and register map of the converter digital front end
package dac_front_pkg;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int DATA_W = 8;
   localparam int TOP_W = 3;
   localparam int LOW_W = 5;
   localparam int THERM_W = 7;
   localparam int UNITS_W = 9;
   localparam int ADDR_W = 4;
   localparam int BUS_W = 32;

   // ****************************************************************
   // Timing and weights
   // ****************************************************************
   localparam real CLK_MHZ = 125.0;
   localparam int CONV_DIV = 2;          // System clocks per conversion
   localparam int FULL_UNITS = 255;      // Full scale in low-bit units
   localparam int RETRACE_PERMIL = 104;  // 10.4 percent of full scale
   localparam logic [UNITS_W-1:0] RETRACE_UNITS =
      UNITS_W'(FULL_UNITS * RETRACE_PERMIL / 1000);
   localparam int FIFO_DEPTH = 4;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] REG_CODE = 4'h8;
   localparam int CTRL_CONV_EN = 0;
   localparam int CTRL_RETRACE_EN = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;
   localparam int STAT_UNDERRUN = 0;
   localparam int STAT_SELECT = 1;
   localparam int STAT_LEVEL_LSB = 4;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic retrace;
      logic [DATA_W-1:0] data;
   } sample_s;

   typedef struct packed {
      logic valid;
      logic strap_on;
      logic retrace_force;
      logic word_select;
      logic [DATA_W-1:0] secondary;
      logic [DATA_W-1:0] primary;
   } pins_s;

endpackage : dac_front_pkg

// File: tb/sample_source.sv
// Behavioural sample source driving the two words and the controls
`timescale 1ns/10ps

module sample_source (
   input wire logic i_clk,
   output logic [dac_front_pkg::DATA_W-1:0] o_primary_word,
   output logic [dac_front_pkg::DATA_W-1:0] o_secondary_word,
   output logic o_word_select,
   output logic o_retrace_force,
   output logic o_sample_valid
);
   import dac_front_pkg::*;

   // ****************************************************************
   // Pin driving
   // ****************************************************************
   // Idle: retrace tied low, primary selected so no blank can stick
   initial begin
      o_primary_word = 8'h00;
      o_secondary_word = 8'hff;
      o_word_select = 1'b1;
      o_retrace_force = 1'b0;
      o_sample_valid = 1'b0;
   end

   // One cycle; the word not offered is scrambled, never left stale
   task automatic drive(input logic sel, input logic ret,
                        input logic [7:0] w, input logic vld);
      @(posedge i_clk);
      o_word_select <= sel;
      o_retrace_force <= ret;
      o_sample_valid <= vld;
      o_primary_word <= (vld && sel) ? w : ~w;
      o_secondary_word <= (vld && !sel) ? w : ~w;
   endtask : drive

   // Released lines toggle each cycle so nothing stale looks valid
   task automatic idle(input int n);
      for (int k = 0; k < n; k++) begin
         @(posedge i_clk);
         o_sample_valid <= 1'b0;
         o_primary_word <= ~o_primary_word;
         o_secondary_word <= ~o_secondary_word;
      end
   endtask : idle

endmodule : sample_source

// File: tb/testbench.sv
// Self-checking bench for the converter front end
`timescale 1ns/10ps

module testbench;
   import dac_front_pkg::*;

   // ****************************************************************
   // Signals
   // ****************************************************************
   logic i_clk = 1'b0;
   logic i_reset = 1'b1;
   logic [7:0] pw;
   logic [7:0] sw;
   logic sel;
   logic ret;
   logic vld;
   logic strap = 1'b1;
   logic ctrl_ret = 1'b1;
   logic ret_hold = 1'b0;
   logic [7:0] last_d = 8'h00;
   logic o_sample_ready;
   logic [3:0] i_addr;
   logic [31:0] i_wdata;
   logic [31:0] code_exp;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic rd_d = 1'b0;
   logic [31:0] o_rdata;
   logic [6:0] o_therm;
   logic [4:0] o_low_bits;
   logic o_retrace_bit;
   logic [8:0] o_true_units;
   logic [31:0] seen;
   logic [31:0] last_seen = 32'h0000_0000;
   logic [31:0] exp_q[$];
   logic [31:0] rd_q[$];
   int err_count = 0;
   int checks = 0;
   int seed = 32'h6c72;

   always #4 i_clk = ~i_clk;

   sample_source sample_source_i (.i_clk(i_clk), .o_primary_word(pw),
      .o_secondary_word(sw), .o_word_select(sel),
      .o_retrace_force(ret), .o_sample_valid(vld));

   // Full-rate conversion so back-to-back words do not overflow
   dac_front_end #(.CONV_DIV_P(1), .FIFO_DEPTH_P(4)) dac_front_end_i (
      .i_clk(i_clk), .i_reset(i_reset), .i_primary_word(pw),
      .i_secondary_word(sw), .i_word_select(sel), .i_retrace_force(ret),
      .i_sample_valid(vld), .i_retrace_current_on(strap),
      .o_sample_ready(o_sample_ready), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_therm(o_therm),
      .o_low_bits(o_low_bits), .o_retrace_bit(o_retrace_bit),
      .o_true_units(o_true_units));

   assign seen = {10'h000, o_therm, o_low_bits, o_retrace_bit,
                  o_true_units};

   // ****************************************************************
   // Checking helpers
   // ****************************************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out

   // Output image for a latched word and its retrace state
   function automatic logic [31:0] expect_out(input logic [7:0] d,
                                              input logic r);
      logic [6:0] th;
      logic rb;
      th = 7'h00;
      for (int k = 0; k < 7; k++) begin
         th[k] = (k < d[7:5]);
      end
      rb = r & strap & ctrl_ret;
      return {10'h000, th, d[4:0], rb,
              {1'b0, d} + (rb ? RETRACE_UNITS : 9'h000)};
   endfunction : expect_out

   // Notes the expectation, then offers the word
   task automatic send(input logic s, input logic r, input logic [7:0] w,
                       input logic v);
      logic [7:0] d;
      if (s) begin
         ret_hold = r;
      end
      d = ret_hold ? 8'hff : w;
      if (v) begin
         exp_q.push_back(expect_out(d, ret_hold));
         last_d = d;
      end
      sample_source_i.drive(s, r, w, v);
   endtask : send

   // Random word never all ones and never equal to the last one, except on a last of 8'hfe: 8'hff flips onto it and 8'hfe flips to 8'hff; so every push shows
   task automatic send_rand(input logic s);
      logic [7:0] w;
      w = 8'($random(seed));
      if (w == last_d || w == 8'hff) begin
         w = w ^ 8'h01;
      end
      send(s, 1'b0, w, 1'b1);
   endtask : send_rand

   // Bits above the two used ones carry random filler
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] r;
      r = $random(seed);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= {r[31:2], d[1:0]};
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
      rd_q.push_back(exp);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      i_wdata <= $random(seed); // Reads ignore write data
      @(posedge i_clk);
      i_rd <= 1'b0;
   endtask : reg_rd

   // ****************************************************************
   // Monitor
   // ****************************************************************
   // Each visible change of the switch lines takes the oldest note
   always @(posedge i_clk) begin
      rd_d <= i_rd;
      if (rd_d) begin
         check(o_rdata, rd_q.pop_front());
      end
      if (!i_reset && seen !== last_seen) begin
         if (exp_q.size() == 0) begin
            err_count++;
            $display("[ERR] %0t output changed unexpectedly", $time);
         end else begin
            check(seen, exp_q.pop_front());
         end
      end
      last_seen = seen;
   end

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      #(8 * 20000);
      err_count++;
      $display("[ERR] %0t watchdog expired", $time);
      close_out();
   end

   initial begin
      i_addr <= 4'($random(seed));
      i_wdata <= $random(seed);
      repeat (5) @(posedge i_clk);
      i_reset <= 1'b0;
      reg_rd(REG_CTRL, 32'h0000_0003);
      // Any address in the upper quarter is unmapped
      reg_wr({2'b11, 2'($random(seed))}, 32'hffff_ffff);
      reg_rd({2'b11, 2'($random(seed))}, 32'h0000_0000);
      $display("test registers done");
      // Interleaved words, select toggling every conversion for eight words, then eight on secondary
      for (int k = 0; k < 8; k++) begin
         send_rand(k % 2 == 0);
      end
      for (int k = 0; k < 8; k++) begin
         send_rand(1'b0);
      end
      sample_source_i.idle(10);
      $display("test interleave done");
      // Retrace sampled only while primary selected
      send_rand(1'b1);
      // Word always differs from the last and is never all ones
      send(1'b0, 1'b1, (last_d ^ 8'h21) & 8'h7f, 1'b1);
      send(1'b1, 1'b1, 8'h00, 1'b0);
      send(1'b0, 1'b0, 8'h42, 1'b1);
      sample_source_i.idle(8);
      send_rand(1'b1);
      sample_source_i.idle(8);
      $display("test retrace hold done");
      // Strap and enable gating of the retrace switch
      for (int g = 0; g < 4; g++) begin
         // Clear retrace from the latch before the gating moves
         send_rand(1'b1);
         sample_source_i.idle(8);
         strap <= g[0];
         ctrl_ret = g[1];
         reg_wr(REG_CTRL, {30'h0, g[1], 1'b1});
         sample_source_i.idle(4);
         send(1'b1, 1'b1, 8'h5a, 1'b1);
         sample_source_i.idle(8);
      end
      strap <= 1'b1;
      ctrl_ret = 1'b1;
      send_rand(1'b1);
      sample_source_i.idle(8);
      $display("test retrace strap done");
      // Stall conversion, fill the buffer past full, then drain
      reg_wr(REG_CTRL, 32'h0000_0002);
      reg_wr(REG_STATUS, 32'h0000_0001);
      send(1'b1, 1'b0, 8'h3c ^ last_d, 1'b1);
      for (int k = 0; k < 9; k++) begin
         sample_source_i.drive(1'b1, 1'b0, last_d, 1'b1);
      end
      sample_source_i.idle(4);
      check(32'(o_sample_ready), 32'h0000_0000);
      reg_rd(REG_STATUS, 32'h0000_0042);
      reg_wr(REG_CTRL, 32'h0000_0003);
      sample_source_i.idle(10);
      reg_rd(REG_STATUS, 32'h0000_0003);
      code_exp = expect_out(last_d, 1'b0);
      reg_rd(REG_CODE, {19'h0, code_exp[9], code_exp[21:10]});
      sample_source_i.idle(4);
      $display("test fill drain done");
      check(32'(exp_q.size()), 32'h0000_0000);
      close_out();
   end

endmodule : testbench
